// >>> cod_core.sv
/*
  Operand decode core with register file and status word, reached over
  AHB-Lite. Assumes a single master and one clock, hclk, the CPU clock.
*/
// Summary of operation
// RL1 - General register field numbers X0 A1 C2 B3 E4 D5 L6 H7.
// RL2 - Register pair field numbers AX0 BC1 DE2 HL3.
// RL3 - Pair n uses byte 2n as low and 2n+1 as high.
// RL4 - Short-direct operands lie in FE20H..FF1FH; the pair form must be even.
// RL5 - Absolute addresses span the full 16 bits; word transfers need even addresses.
// RL6 - Table operand picks an even word address in 0040H..007FH.
// RL7 - Branch displacement is signed 8-bit, sign-extended, added to the program counter.
// RL8 - Bit operand is 3 bits, one of eight bits in a byte.
// RL9 - Byte immediates are 8 bits, word immediates 16 bits.
// RL10 - A is the byte accumulator, AX the word accumulator.
// RL11 - A 16-bit register is reachable as separate high and low bytes.
// RL12 - Each flag is kept, cleared, set or computed as the command says.
// RL13 - Restoring commands reload flags from the saved copy.
// RL14 - Status word holds carry, auxiliary carry, zero and interrupt enable.
// RL15 - A flag stands while a non-maskable interrupt is in service.
// RL16 - One instruction clock is one CPU clock; one command per clock. The core takes one command per bus write, at most one every two clocks.
`timescale 1ns/1ps
`default_nettype none
`include "cod_map.svh"
module cod_core #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [7:0] program_status_word,
  output logic nmi_in_service_flag
);
  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_chk
    $error("ADDR_W must lie between 5 and 8");
  end

  cod_pkg::cod_phase_type phase, next_phase;
  logic [7:0] addr, next_addr;
  logic wr, next_wr;
  logic [7:0] regs [8];
  logic [7:0] next_regs [8];
  logic [7:0] save, next_save;
  logic [7:0] next_psw;
  logic next_nmi_in_service_flag;
  logic [31:0] opnd, next_opnd;
  logic [31:0] rslt, next_rslt;
  logic [15:0] pc, next_pc;
  logic [31:0] next_rdata;
  logic next_ready;
  logic do_exec;
  logic do_opnd;
  cod_pkg::cod_cmd_type cmd;
  cod_pkg::cod_kind_type kind;
  logic [15:0] val;
  logic [7:0] acc, src, res;
  logic cin, c_out, ac_out;
  logic [8:0] wide;
  logic [4:0] nib;

  function automatic logic in_short(input logic [15:0] v);
    in_short = v >= `COD_SHORT_LO && v <= `COD_SHORT_HI;
  endfunction

  function automatic logic flag_apply(input cod_pkg::cod_fact_type f, input logic old,
    input logic calc);
    case (f)
      cod_pkg::F_CLR: flag_apply = 1'b0;
      cod_pkg::F_SET: flag_apply = 1'b1;
      cod_pkg::F_CALC: flag_apply = calc;
      default: flag_apply = old;
    endcase
  endfunction

  assign hresp = 1'b0;
  assign do_exec = phase == cod_pkg::BUS_DATA && wr && addr == `COD_OFS_EXEC;
  assign do_opnd = phase == cod_pkg::BUS_DATA && wr && addr == `COD_OFS_OPND;
  assign cmd = cod_pkg::cod_cmd_type'(hwdata[21:0]);
  assign kind = cod_pkg::cod_kind_type'(hwdata[`COD_OP_KIND]);
  assign val = hwdata[`COD_OP_VAL];

  // Arithmetic on the byte accumulator, register or immediate source
  always_comb
  begin
    acc = regs[`COD_REG_A]; // RL10
    src = cmd.src ? regs[cmd.r] : cmd.imm; // RL1 RL9
    cin = (cmd.op == cod_pkg::OP_ADDC || cmd.op == cod_pkg::OP_SUBC)
      && program_status_word[`COD_PSW_CY];
    wide = 9'h000;
    nib = 5'h00;
    case (cmd.op)
      cod_pkg::OP_ADD, cod_pkg::OP_ADDC:
      begin
        wide = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
        nib = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
      end
      cod_pkg::OP_SUB, cod_pkg::OP_SUBC:
      begin
        wide = {1'b0, acc} - {1'b0, src} - {8'h00, cin};
        nib = {1'b0, acc[3:0]} - {1'b0, src[3:0]} - {4'h0, cin};
      end
      cod_pkg::OP_AND: wide = {1'b0, acc & src};
      cod_pkg::OP_OR: wide = {1'b0, acc | src};
      cod_pkg::OP_XOR: wide = {1'b0, acc ^ src};
      default: wide = {1'b0, src};
    endcase
    res = wide[7:0];
    c_out = wide[8];
    ac_out = nib[4];
  end

  always_comb
  begin
    next_phase = phase;
    next_addr = addr;
    next_wr = wr;
    next_regs = regs;
    next_save = save;
    next_psw = program_status_word;
    next_nmi_in_service_flag = nmi_in_service_flag;
    next_opnd = opnd;
    next_rslt = rslt;
    next_pc = pc;
    next_rdata = hrdata;
    next_ready = 1'b1;
    case (phase)
      cod_pkg::BUS_IDLE:
        if (hsel && hready && htrans[1])
        begin
          next_phase = cod_pkg::BUS_DATA;
          next_addr = 8'({haddr[ADDR_W-1:2], 2'b00});
          next_wr = hwrite;
          next_ready = 1'b0;
        end
      cod_pkg::BUS_DATA:
      begin
        // One wait state lets every write settle before the next read is served
        next_phase = cod_pkg::BUS_IDLE;
        if (!wr)
        begin
          case (addr)
            `COD_OFS_GPRL: next_rdata = {regs[3], regs[2], regs[1], regs[0]}; // RL11
            `COD_OFS_GPRH: next_rdata = {regs[7], regs[6], regs[5], regs[4]};
            `COD_OFS_PSW: next_rdata = {23'h000000, nmi_in_service_flag, program_status_word};
            `COD_OFS_SAVE: next_rdata = {24'h000000, save};
            `COD_OFS_OPND: next_rdata = opnd;
            `COD_OFS_RSLT: next_rdata = rslt;
            `COD_OFS_PC: next_rdata = {16'h0000, pc};
            default: next_rdata = 32'h00000000;
          endcase
        end
        else
        begin
          case (addr)
            `COD_OFS_GPRL: for (int i = 0; i < 4; i++) next_regs[i] = hwdata[8*i +: 8];
            `COD_OFS_GPRH: for (int i = 0; i < 4; i++) next_regs[i+4] = hwdata[8*i +: 8];
            `COD_OFS_PSW: next_psw = hwdata[7:0];
            `COD_OFS_SAVE: next_save = hwdata[7:0];
            `COD_OFS_PC: next_pc = hwdata[15:0];
            `COD_OFS_OPND:
            begin
              next_opnd = {12'h000, hwdata[19:0]};
              next_rslt = {1'b1, 15'h0000, val};
              case (kind)
                cod_pkg::K_SADDR: next_rslt[`COD_RS_VALID] = in_short(val); // RL4
                cod_pkg::K_SADDRP: next_rslt[`COD_RS_VALID] = in_short(val) && !val[0]; // RL4
                cod_pkg::K_ABS16: next_rslt[`COD_RS_VALID] = !val[0]; // RL5
                cod_pkg::K_TABLE: next_rslt[15:0] = `COD_TABLE_BASE + {10'h000, val[4:0], 1'b0}; // RL6
                cod_pkg::K_DISP: next_rslt[15:0] = pc + {{8{val[7]}}, val[7:0]}; // RL7
                cod_pkg::K_BIT: next_rslt[15:0] = {8'h00, 8'h01 << val[2:0]}; // RL8
                cod_pkg::K_IMM8: next_rslt[15:0] = {8'h00, val[7:0]}; // RL9
                default: next_rslt[15:0] = val; // RL5 RL9
              endcase
            end
            `COD_OFS_EXEC:
            begin
              // Flags follow the command's per-flag action; restores and NMI entry bypass them
              next_psw[`COD_PSW_Z] = flag_apply(cmd.fz, program_status_word[`COD_PSW_Z],
                res == 8'h00); // RL12 RL14
              next_psw[`COD_PSW_AC] = flag_apply(cmd.fac, program_status_word[`COD_PSW_AC],
                ac_out); // RL12
              next_psw[`COD_PSW_CY] = flag_apply(cmd.fcy, program_status_word[`COD_PSW_CY],
                c_out); // RL12
              case (cmd.op)
                cod_pkg::OP_MOV: next_regs[cmd.r] = cmd.imm; // RL1
                cod_pkg::OP_MOVW:
                begin
                  next_regs[{cmd.r[1:0], 1'b0}] = opnd[7:0]; // RL2 RL3
                  next_regs[{cmd.r[1:0], 1'b1}] = opnd[15:8]; // RL3
                end
                cod_pkg::OP_ADD, cod_pkg::OP_ADDC, cod_pkg::OP_SUB, cod_pkg::OP_SUBC,
                cod_pkg::OP_AND, cod_pkg::OP_OR, cod_pkg::OP_XOR:
                  next_regs[`COD_REG_A] = res; // RL10
                cod_pkg::OP_SAVE: next_save = program_status_word;
                cod_pkg::OP_RESTORE: next_psw = save; // RL13
                cod_pkg::OP_NMI:
                begin
                  next_save = program_status_word;
                  next_psw = program_status_word;
                  next_psw[`COD_PSW_IE] = 1'b0; // RL14
                  next_nmi_in_service_flag = 1'b1; // RL15
                end
                cod_pkg::OP_RETN:
                begin
                  next_psw = save; // RL13
                  next_nmi_in_service_flag = 1'b0; // RL15
                end
                // No-op and spare codes keep only the flag actions above
                default: next_save = save;
              endcase
              next_pc = pc + 16'h0001; // RL16
            end
            default: next_pc = pc;
          endcase
        end
      end
      default: next_phase = cod_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase <= cod_pkg::BUS_IDLE;
      addr <= 8'h00;
      wr <= 1'b0;
      for (int i = 0; i < 8; i++) regs[i] <= 8'h00;
      save <= `COD_PSW_RST;
      program_status_word <= `COD_PSW_RST;
      nmi_in_service_flag <= 1'b0;
      opnd <= 32'h00000000;
      rslt <= 32'h00000000;
      pc <= `COD_PC_RST;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
    end
    else
    begin
      phase <= next_phase;
      addr <= next_addr;
      wr <= next_wr;
      regs <= next_regs;
      save <= next_save;
      program_status_word <= next_psw;
      nmi_in_service_flag <= next_nmi_in_service_flag;
      opnd <= next_opnd;
      rslt <= next_rslt;
      pc <= next_pc;
      hrdata <= next_rdata;
      hreadyout <= next_ready;
    end
  end

  a_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
    phase == cod_pkg::BUS_IDLE && hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("data phase is not one wait state long");
  a_pair_alias: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
    do_exec && cmd.op == cod_pkg::OP_MOVW |=>
    {regs[{$past(cmd.r[1:0]), 1'b1}], regs[{$past(cmd.r[1:0]), 1'b0}]} == $past(opnd[15:0]))
    else $error("pair write did not land on its byte registers");
  a_short_range: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
    do_opnd && kind == cod_pkg::K_SADDRP && (val[0] || val < 16'hFE20) |=> !rslt[31])
    else $error("bad short-direct pair accepted");
  a_table_word: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
    do_opnd && kind == cod_pkg::K_TABLE |=>
    rslt[15:0] >= 16'h0040 && rslt[15:0] <= 16'h007F && !rslt[0])
    else $error("table address out of region");
  a_disp_sext: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
    do_opnd && kind == cod_pkg::K_DISP && val[7] |=> rslt[15:0] < $past(pc) || $past(pc) < 16'h0080)
    else $error("negative displacement not sign-extended");
  a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
    do_exec && cmd.fz == cod_pkg::F_CLR && cmd.op <= cod_pkg::OP_SAVE |=> !program_status_word[6])
    else $error("zero flag not cleared");
  a_flag_restore: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
    do_exec && cmd.op == cod_pkg::OP_RESTORE |=> program_status_word == $past(save))
    else $error("flags not restored from saved copy");
  a_nmi_service: assert property (@(posedge hclk) disable iff (!hresetn) // RL15
    do_exec && cmd.op == cod_pkg::OP_NMI |=> nmi_in_service_flag && !program_status_word[7]
    ##1 nmi_in_service_flag)
    else $error("service flag not raised");
  a_pc_step: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
    do_exec |=> pc == $past(pc) + 16'h0001)
    else $error("program counter did not step by one");
  a_bit_onehot: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
    do_opnd && kind == cod_pkg::K_BIT |=> rslt[31] && $onehot(rslt[15:0]))
    else $error("bit operand does not select a single bit");
  a_short_valid: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
    do_opnd && kind == cod_pkg::K_SADDR |=>
    rslt[31] == ($past(val) >= `COD_SHORT_LO && $past(val) <= `COD_SHORT_HI))
    else $error("short-direct range check wrong");
  a_abs_even: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
    do_opnd && kind == cod_pkg::K_ABS16 |=> rslt[31] == !$past(val[0]))
    else $error("word address alignment check wrong");
endmodule
`default_nettype wire

// >>> cod_map.svh
/*
  Register offsets, field positions, reset values and operand limits
  of the operand decode core. Included by the core; holds definitions only.
*/
`ifndef COD_MAP_SVH
`define COD_MAP_SVH
`define COD_OFS_GPRL 8'h00
`define COD_OFS_GPRH 8'h04
`define COD_OFS_PSW 8'h08
`define COD_OFS_SAVE 8'h0C
`define COD_OFS_OPND 8'h10
`define COD_OFS_RSLT 8'h14
`define COD_OFS_PC 8'h18
`define COD_OFS_EXEC 8'h1C
`define COD_PSW_IE 7
`define COD_PSW_Z 6
`define COD_PSW_AC 4
`define COD_PSW_CY 0
`define COD_PSW_RST 8'h00
`define COD_PC_RST 16'h0000
`define COD_REG_A 3'h1
`define COD_SHORT_LO 16'hFE20
`define COD_SHORT_HI 16'hFF1F
`define COD_TABLE_BASE 16'h0040
`define COD_EX_IMM 7:0
`define COD_EX_REG 10:8
`define COD_EX_SRC 11
`define COD_EX_OP 15:12
`define COD_EX_FZ 17:16
`define COD_EX_FAC 19:18
`define COD_EX_FCY 21:20
`define COD_OP_VAL 15:0
`define COD_OP_KIND 19:16
`define COD_RS_VALID 31
`endif

// >>> cod_pkg.sv
/*
  Types of the operand decode core: operand kinds, operations, flag actions,
  the decoded command and the bus phase. Assumes nothing of its users.
*/
`default_nettype none
package cod_pkg;
  typedef enum logic [3:0] {K_SADDR, K_SADDRP, K_ABS8, K_ABS16, K_TABLE, K_DISP, K_BIT, K_IMM8,
    K_IMM16} cod_kind_type;
  typedef enum logic [3:0] {OP_NOP, OP_MOV, OP_MOVW, OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_AND,
    OP_OR, OP_XOR, OP_SAVE, OP_RESTORE, OP_NMI, OP_RETN} cod_op_type;
  typedef enum logic [1:0] {F_KEEP, F_CLR, F_SET, F_CALC} cod_fact_type;
  typedef struct packed {
    cod_fact_type fcy;
    cod_fact_type fac;
    cod_fact_type fz;
    cod_op_type op;
    logic src;
    logic [2:0] r;
    logic [7:0] imm;
  } cod_cmd_type;
  typedef enum logic {BUS_IDLE, BUS_DATA} cod_phase_type;
endpackage
`default_nettype wire

// >>> tb_cpu_operand_decode.sv
/*
  Self-checking bench of the operand decode core, driven over AHB-Lite.
  Assumes cod_pkg, cod_map.svh and cod_core are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cod_map.svh"
module tb_cpu_operand_decode;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, nmi_in_service_flag, rdy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdat, got;
  logic [7:0] program_status_word;
  int failures = 0;
  int samples_checked = 0;
  int i;
  // Operand kind and value, then valid bit and decoded value
  localparam logic [19:0] OPV [15] = '{20'h0FE20, 20'h0FF1F, 20'h0FE1F, 20'h0FF20, 20'h1FE21, 20'h1FE22,
    20'h21235, 20'h31235, 20'h31234, 20'h4001F, 20'h50080, 20'h5007F, 20'h60005, 20'h701AB, 20'h8BEEF};
  localparam logic [16:0] EXP [15] = '{17'h1FE20, 17'h1FF1F, 17'h0, 17'h0, 17'h0, 17'h1FE22,
    17'h11235, 17'h0, 17'h11234, 17'h1007E, 17'h10080, 17'h1017F, 17'h10020, 17'h100AB, 17'h1BEEF};

  cod_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .program_status_word(program_status_word),
    .nmi_in_service_flag(nmi_in_service_flag));

  // Copied at the falling edge so the rising edge sees settled values, free of update races
  always @(negedge hclk)
  begin
    rdy = hreadyout;
    rdat = hrdata;
  end

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    samples_checked++;
    if ((g & m) !== (e & m))
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g & m, e & m);
    end
  endtask

  task automatic check_psw(input logic [7:0] e, input logic n);
    check_word({23'h0, nmi_in_service_flag, program_status_word}, {23'h0, n, e}, 32'h1FF);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (rdy !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      $display("wrong value at %0t: bus never ready", $time);
    end
  endtask

  // Entered just after a rising edge; holds each phase until ready is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    got = rdat;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    check_word(got, e, m);
  endtask

  // Action field is CY, AC, Z, two bits each: 0 keep, 1 clear, 2 set, 3 compute
  task automatic ex(input cod_pkg::cod_op_type op, input logic [2:0] r, input logic [7:0] imm,
    input logic src, input logic [5:0] act);
    bus(1'b1, `COD_OFS_EXEC, {10'h0, act, op, src, r, imm});
  endtask

  initial
  begin
    repeat (3000) @(posedge hclk);
    failures++;
    complete_run();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_psw(8'h00, 1'b0);
    rd_chk(`COD_OFS_GPRL, 32'h0, '1);
    rd_chk(`COD_OFS_PC, 32'h0, 32'hFFFF);
    check_word({31'h0, hresp}, 32'h0, '1);
    for (i = 0; i < 8; i++)
      ex(cod_pkg::OP_MOV, 3'(i), 8'(8'h10 + i), 1'b0, 6'h00);
    rd_chk(`COD_OFS_GPRL, 32'h13121110, '1);
    rd_chk(`COD_OFS_GPRH, 32'h17161514, '1);
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, `COD_OFS_OPND, {12'h0, 4'h8, 16'hA0B0 + 16'(i)});
      ex(cod_pkg::OP_MOVW, 3'(i), 8'h00, 1'b0, 6'h00);
    end
    rd_chk(`COD_OFS_GPRL, 32'hA0B1A0B0, '1);
    rd_chk(`COD_OFS_GPRH, 32'hA0B3A0B2, '1);
    bus(1'b1, `COD_OFS_GPRL, 32'h00000F01);
    ex(cod_pkg::OP_ADD, 3'h0, 8'h00, 1'b1, 6'h3F);
    rd_chk(`COD_OFS_GPRL, 32'h00001001, 32'hFFFF);
    check_psw(8'h10, 1'b0);
    ex(cod_pkg::OP_ADD, 3'h0, 8'hF0, 1'b0, 6'h3F);
    check_psw(8'h41, 1'b0);
    ex(cod_pkg::OP_ADDC, 3'h0, 8'h00, 1'b0, 6'h3F);
    check_psw(8'h00, 1'b0);
    ex(cod_pkg::OP_SUB, 3'h0, 8'h02, 1'b0, 6'h3F);
    check_psw(8'h11, 1'b0);
    ex(cod_pkg::OP_SUBC, 3'h0, 8'h0E, 1'b0, 6'h3F);
    check_psw(8'h00, 1'b0);
    ex(cod_pkg::OP_XOR, 3'h0, 8'hF0, 1'b0, 6'h03);
    check_psw(8'h40, 1'b0);
    ex(cod_pkg::OP_OR, 3'h0, 8'h0C, 1'b0, 6'h03);
    check_psw(8'h00, 1'b0);
    ex(cod_pkg::OP_AND, 3'h0, 8'h03, 1'b0, 6'h03);
    check_psw(8'h40, 1'b0);
    rd_chk(`COD_OFS_GPRL, 32'h00000001, 32'hFFFF);
    bus(1'b1, `COD_OFS_PSW, 32'h81);
    ex(cod_pkg::OP_NOP, 3'h0, 8'h00, 1'b0, 6'h06);
    check_psw(8'hC1, 1'b0);
    ex(cod_pkg::OP_NOP, 3'h0, 8'h00, 1'b0, 6'h18);
    check_psw(8'hD0, 1'b0);
    ex(cod_pkg::OP_NOP, 3'h0, 8'h00, 1'b0, 6'h21);
    check_psw(8'h91, 1'b0);
    bus(1'b1, `COD_OFS_PC, 32'h0100);
    for (i = 0; i < 15; i++)
    begin
      bus(1'b1, `COD_OFS_OPND, {12'h0, OPV[i]});
      rd_chk(`COD_OFS_OPND, {12'h0, OPV[i]}, '1);
      rd_chk(`COD_OFS_RSLT, {EXP[i][16], 15'h0, EXP[i][15:0]},
        {1'b1, 15'h0, {16{EXP[i][16]}}});
    end
    ex(cod_pkg::OP_NOP, 3'h0, 8'h00, 1'b0, 6'h00);
    rd_chk(`COD_OFS_PC, 32'h0101, 32'hFFFF);
    bus(1'b1, `COD_OFS_PSW, 32'h91);
    ex(cod_pkg::OP_NMI, 3'h0, 8'h00, 1'b0, 6'h00);
    check_psw(8'h11, 1'b1);
    rd_chk(`COD_OFS_PSW, 32'h111, 32'h1FF);
    rd_chk(`COD_OFS_SAVE, 32'h91, 32'hFF);
    bus(1'b1, `COD_OFS_PSW, 32'h40);
    ex(cod_pkg::OP_RETN, 3'h0, 8'h00, 1'b0, 6'h00);
    check_psw(8'h91, 1'b0);
    bus(1'b1, `COD_OFS_SAVE, 32'h50);
    ex(cod_pkg::OP_RESTORE, 3'h0, 8'h00, 1'b0, 6'h20);
    check_psw(8'h50, 1'b0);
    bus(1'b1, `COD_OFS_PSW, 32'h01);
    ex(cod_pkg::OP_SAVE, 3'h0, 8'h00, 1'b0, 6'h00);
    rd_chk(`COD_OFS_SAVE, 32'h01, 32'hFF);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h0, '1);
    rd_chk(`COD_OFS_EXEC, 32'h0, '1);
    complete_run();
  end
endmodule
`default_nettype wire
